/* File: rtl/acs_consts.svh */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// Register addresses
`define ACS_ADDR_CTRL        4'h0
`define ACS_ADDR_ADJUST      4'h4
`define ACS_ADDR_VALUES      4'h5
`define ACS_ADDR_PWR         4'hA
// Field positions
`define ACS_CTRL_START_BIT   15
`define ACS_ADJ_SEQ_BIT      14
`define ACS_ADJ_DUR_HI       13
`define ACS_ADJ_DUR_LO       12
`define ACS_ADJ_STORE_BIT    7
`define ACS_PWR_I_BIT        0
`define ACS_PWR_Q_BIT        1
// Reset values
`define ACS_ADJUST_RESET     16'h4000
// Array geometry
`define ACS_ARRAY_WORDS      183
`define ACS_READS            184
`define ACS_WRITES           185
// Timing counts in sampling clock cycles
`define ACS_FLUSH_CYCLES     60
`define ACS_START_LOW_CYC    1280
`define ACS_START_HIGH_CYC   1280
`define ACS_DLY_SHORT_CYC    4096
`define ACS_DLY_LONG_CYC     65536
`define ACS_TRIM_TERM_CYC    2048
`define ACS_LIN_CYC0         4096
`define ACS_LIN_CYC1         2048
`define ACS_LIN_CYC2         1024

`endif

/* File: rtl/acs_pkg.sv */
package acs_pkg;
    typedef struct packed {
        logic [9:0] inPhase;
        logic [9:0] inPhaseDelayed;
        logic [9:0] quadrature;
        logic [9:0] quadratureDelayed;
        logic       rangeI;
        logic       rangeQ;
    } acs_lanes_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } acs_reg_req_t;

    typedef enum logic [2:0] {
        ST_DELAY = 3'b000,
        ST_IDLE  = 3'b001,
        ST_TERM  = 3'b010,
        ST_LIN   = 3'b011,
        ST_FLUSH = 3'b100
    } acs_state_t;
endpackage

/* File: rtl/acs_calibration_sequencer.sv */
// Function
// - Power-up trim after pin-selected delay
// - Delay pin change launches a trim
// - Start high at power-up skips trim
// - Sequence bit 14 selects termination trims
// - Duration field picks one of three
// - Constants array behind value register
// - Save: enable, power down, 184 reads
// - Restore: same framing, 185 writes
// - Both powered down suspends trim
// - Lanes and range flags low, clock runs
// - Outputs valid 60 cycles after done
// - Power-down is pin OR register bit
// - Start needs low then high hold
// - Active flag high during trim
`include "acs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module acs_calibration_sequencer #(
    parameter int DLY_SHORT = `ACS_DLY_SHORT_CYC,
    parameter int DLY_LONG  = `ACS_DLY_LONG_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 trimStartPin,
    input  wire logic                 trimDelaySelect,
    input  wire logic                 powerDownInPhase,
    input  wire logic                 powerDownQuadrature,
    input  wire logic                 extendedControlMode,
    input  wire acs_pkg::acs_reg_req_t regReq,
    input  wire acs_pkg::acs_lanes_t  convData,
    output var  acs_pkg::acs_lanes_t  laneOut,
    output logic                      outputDataClock,
    output logic [15:0]               regRdata,
    output logic                      trimActiveFlag,
    output logic                      outputValid,
    output logic                      powerDownI,
    output logic                      powerDownQ,
    output logic                      chipPoweredDown
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pinMeta_q;
    logic [4:0] pinSync_q;
    logic       calPin, dlyPin, pdiPin, pdqPin, ecmPin;

    // Two flops per pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= 5'h00;
            pinSync_q <= 5'h00;
        end else begin
            pinMeta_q <= {extendedControlMode, powerDownQuadrature,
                          powerDownInPhase, trimDelaySelect, trimStartPin};
            pinSync_q <= pinMeta_q;
        end
    end
    assign {ecmPin, pdqPin, pdiPin, dlyPin, calPin} = pinSync_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        startBit_q;
    logic [15:0] adjust_q;
    logic [1:0]  pwrBits_q;
    logic        storeEn;
    logic        power_down_in_phase, power_down_quadrature, bothDown;

    assign storeEn  = adjust_q[`ACS_ADJ_STORE_BIT];
    assign power_down_in_phase      = pdiPin | (ecmPin & pwrBits_q[`ACS_PWR_I_BIT]);
    assign power_down_quadrature      = pdqPin | (ecmPin & pwrBits_q[`ACS_PWR_Q_BIT]);
    assign bothDown = power_down_in_phase & power_down_quadrature;

    // Control register writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            startBit_q <= 1'b0;
            adjust_q   <= `ACS_ADJUST_RESET;
            pwrBits_q  <= 2'h0;
        end else if (regReq.wr) begin
            case (regReq.addr)
                `ACS_ADDR_CTRL:
                    startBit_q <= regReq.wdata[`ACS_CTRL_START_BIT];
                `ACS_ADDR_ADJUST: adjust_q  <= regReq.wdata;
                `ACS_ADDR_PWR:    pwrBits_q <= regReq.wdata[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Constants array and store port
    // ------------------------------------------------------------
    logic [15:0] calArray [0:`ACS_ARRAY_WORDS-1];
    logic [7:0]  portIdx_q;
    logic        portOpen;
    logic [7:0]  ptr;

    assign portOpen = storeEn & bothDown;
    assign ptr = (portIdx_q == 8'h00) ? 8'h00 : portIdx_q - 8'h01;

    // Sequential pointer; reads lead with a dummy word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            portIdx_q <= 8'h00;
        end else if (!portOpen) begin
            portIdx_q <= 8'h00;
        end else if (regReq.addr == `ACS_ADDR_VALUES) begin
            if (regReq.rd && portIdx_q < 8'(`ACS_READS))
                portIdx_q <= portIdx_q + 8'h01;
            else if (regReq.wr && portIdx_q < 8'(`ACS_WRITES))
                portIdx_q <= portIdx_q + 8'h01;
        end
    end

    // Array writes from restore port only (dummies dropped)
    always_ff @(posedge sys_clk) begin
        if (portOpen && regReq.wr && regReq.addr == `ACS_ADDR_VALUES
            && portIdx_q < 8'(`ACS_ARRAY_WORDS))
            calArray[portIdx_q] <= regReq.wdata;
    end

    // Read data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else if (regReq.rd) begin
            case (regReq.addr)
                `ACS_ADDR_CTRL:   regRdata <= {startBit_q, 15'h0000};
                `ACS_ADDR_ADJUST: regRdata <= adjust_q;
                `ACS_ADDR_PWR:    regRdata <= {14'h0000, pwrBits_q};
                `ACS_ADDR_VALUES: regRdata <= (portOpen && portIdx_q != 8'h00
                    && portIdx_q <= 8'(`ACS_ARRAY_WORDS))
                    ? calArray[ptr] : 16'h0000;
                default:          regRdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Start qualifier
    // ------------------------------------------------------------
    logic        startLevel;
    logic [10:0] lowCnt_q, highCnt_q;
    logic        armed_q, cmdStart;

    assign startLevel = calPin | (ecmPin & startBit_q);
    assign cmdStart   = armed_q && startLevel
                        && highCnt_q == 11'(`ACS_START_HIGH_CYC - 1);

    // Low then high hold counting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lowCnt_q  <= 11'h000;
            highCnt_q <= 11'h000;
            armed_q   <= 1'b0;
        end else if (!startLevel) begin
            highCnt_q <= 11'h000;
            if (lowCnt_q == 11'(`ACS_START_LOW_CYC - 1))
                armed_q <= 1'b1;
            else
                lowCnt_q <= lowCnt_q + 11'h001;
        end else begin
            lowCnt_q <= 11'h000;
            if (cmdStart)
                armed_q <= 1'b0;
            else if (armed_q)
                highCnt_q <= highCnt_q + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    acs_state_t  state_q;
    logic [16:0] cnt_q;
    logic        seqSel_q;
    logic [1:0]  durSel_q;
    logic        dlyPrev_q, skipAuto_q, first_q;
    logic        launch;
    logic [16:0] linLen, dlyLen;

    assign launch = cmdStart || (dlyPin != dlyPrev_q);
    assign dlyLen = dlyPin ? 17'(DLY_LONG) : 17'(DLY_SHORT);
    always_comb begin
        case (durSel_q)
            2'b00:   linLen = 17'(`ACS_LIN_CYC0);
            2'b01:   linLen = 17'(`ACS_LIN_CYC1);
            default: linLen = 17'(`ACS_LIN_CYC2);
        endcase
    end

    // Main calibration state machine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_DELAY;
            cnt_q      <= 17'h00000;
            seqSel_q   <= 1'b1;
            durSel_q   <= 2'b00;
            dlyPrev_q  <= 1'b0;
            skipAuto_q <= 1'b0;
            first_q    <= 1'b1;
        end else begin
            dlyPrev_q <= dlyPin;
            first_q   <= 1'b0;
            if (state_q == ST_DELAY && cnt_q == 17'h00002)
                skipAuto_q <= calPin;
            case (state_q)
                ST_DELAY: begin
                    if (cnt_q >= dlyLen - 17'h1) begin
                        cnt_q   <= 17'h00000;
                        state_q <= (skipAuto_q || calPin) ? ST_IDLE
                                   : ST_TERM;
                        seqSel_q <= 1'b1;
                        durSel_q <= 2'b00;
                    end else begin
                        cnt_q <= cnt_q + 17'h1;
                    end
                end
                ST_IDLE, ST_FLUSH: begin
                    if (state_q == ST_FLUSH)
                        cnt_q <= cnt_q + 17'h1;
                    if (state_q == ST_FLUSH
                        && cnt_q == 17'(`ACS_FLUSH_CYCLES - 1)) begin
                        state_q <= ST_IDLE;
                    end
                    if (!first_q && launch && !storeEn) begin
                        seqSel_q <= adjust_q[`ACS_ADJ_SEQ_BIT];
                        durSel_q <= (adjust_q[13:12] == 2'b11) ? 2'b10
                                    : adjust_q[13:12];
                        cnt_q    <= 17'h00000;
                        state_q  <= adjust_q[`ACS_ADJ_SEQ_BIT] ? ST_TERM
                                    : ST_LIN;
                    end
                end
                ST_TERM: begin
                    if (!bothDown) begin
                        if (cnt_q == 17'(`ACS_TRIM_TERM_CYC - 1)) begin
                            cnt_q   <= 17'h00000;
                            state_q <= ST_LIN;
                        end else begin
                            cnt_q <= cnt_q + 17'h1;
                        end
                    end
                end
                ST_LIN: begin
                    if (!bothDown) begin
                        if (cnt_q >= linLen - 17'h1) begin
                            cnt_q   <= 17'h00000;
                            state_q <= ST_FLUSH;
                        end else begin
                            cnt_q <= cnt_q + 17'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic running;
    assign running = state_q == ST_TERM || state_q == ST_LIN;

    // Registered output stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            laneOut         <= '0;
            outputDataClock <= 1'b0;
            trimActiveFlag  <= 1'b0;
            outputValid     <= 1'b0;
            powerDownI      <= 1'b0;
            powerDownQ      <= 1'b0;
            chipPoweredDown <= 1'b0;
        end else begin
            outputDataClock <= ~outputDataClock;
            trimActiveFlag  <= running;
            outputValid     <= state_q == ST_IDLE;
            laneOut         <= (running || state_q == ST_DELAY)
                               ? '0 : convData;
            powerDownI      <= power_down_in_phase;
            powerDownQ      <= power_down_quadrature;
            chipPoweredDown <= bothDown;
        end
    end
endmodule

`default_nettype wire

/* File: verification/acs_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Trim sequencer port checker
// ----------------------------------------
module acs_props
    import acs_pkg::*;
#(
    parameter int DLY_SHORT = 16,
    parameter int DLY_LONG  = 32
) (
    input wire logic         sys_clk,
    input wire logic         rst,
    input wire logic         powerDownInPhase,
    input wire acs_reg_req_t regReq,
    input wire acs_lanes_t   laneOut,
    input wire logic         outputDataClock,
    input wire logic [15:0]  regRdata,
    input wire logic         trimActiveFlag,
    input wire logic         outputValid,
    input wire logic         powerDownI,
    input wire logic         powerDownQ,
    input wire logic         chipPoweredDown
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_lanes_quiet: assert property (
        trimActiveFlag |-> laneOut == '0) else $error("lanes busy in trim");
    chk_clock_runs: assert property (
        trimActiveFlag |=> outputDataClock != $past(outputDataClock))
        else $error("data clock stalled");
    chk_flush_wait: assert property (
        $fell(trimActiveFlag) |-> ##59 (!outputValid ##1 outputValid))
        else $error("flush length wrong");
    chk_valid_apart: assert property (
        trimActiveFlag |-> !outputValid) else $error("valid during trim");
    chk_trim_min: assert property (
        $rose(trimActiveFlag) |-> trimActiveFlag[*8])
        else $error("trim flag too short");
    chk_both_down: assert property (
        chipPoweredDown |-> powerDownI && powerDownQ)
        else $error("chip down with a channel up");
    chk_suspend_hold: assert property (
        trimActiveFlag && chipPoweredDown |=> trimActiveFlag)
        else $error("suspended trim lost");
    chk_port_closed: assert property (
        regReq.rd && regReq.addr == 4'h5
        |=> chipPoweredDown || regRdata == '0)
        else $error("value port open");
    chk_pd_pin: assert property (
        $rose(powerDownInPhase) |-> ##[1:4] powerDownI)
        else $error("pin power-down ignored");
endmodule
bind acs_calibration_sequencer acs_props #(
    .DLY_SHORT(DLY_SHORT),
    .DLY_LONG (DLY_LONG)
) props (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .powerDownInPhase   (powerDownInPhase),
    .regReq             (regReq),
    .laneOut            (laneOut),
    .outputDataClock    (outputDataClock),
    .regRdata           (regRdata),
    .trimActiveFlag     (trimActiveFlag),
    .outputValid        (outputValid),
    .powerDownI         (powerDownI),
    .powerDownQ         (powerDownQ),
    .chipPoweredDown    (chipPoweredDown)
);
`default_nettype wire

/* File: verification/acs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host controller: register bus and start pin
// ----------------------------------------
module acs_host_model
    import acs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] regRdata,
    output acs_reg_req_t     regReq,
    output logic             trimStartPin
);
    // Idle bus and start pin low at time zero
    initial begin
        regReq = '0;
        trimStartPin = 1'b0;
    end
    // One-cycle access; callers stay off the bus while trimming
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        @(negedge sys_clk);
        regReq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        regReq <= '0;
        @(negedge sys_clk);
        q = regRdata;
    endtask
    task automatic setStart(input logic v);
        trimStartPin = v;
    endtask
    // Low hold then high hold launches a commanded trim
    task automatic command();
        trimStartPin = 1'b0;
        repeat (1290) @(negedge sys_clk);
        trimStartPin = 1'b1;
        repeat (1290) @(negedge sys_clk);
        trimStartPin = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acs_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         dlySel = 1'b0;
    logic         power_down_in_phase = 1'b0;
    logic         power_down_quadrature = 1'b0;
    logic         extended_control_mode = 1'b0;
    acs_reg_req_t regReq;
    acs_lanes_t   conv = 42'h2ABCDEF1234;
    acs_lanes_t   lanes;
    logic         startPin, odc, flag, valid, pwrI, pwrQ, chipDown;
    logic [15:0]  rdata, rv;
    int           miscompares = 0;
    int           compares = 0;
    int           cycles = 0;
    int           n;
    // ----------------------------------------
    // Clock, watchdog, design and host
    // ----------------------------------------
    initial forever #5 sys_clk = ~sys_clk;
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end
    acs_calibration_sequencer #(.DLY_SHORT(16), .DLY_LONG(32)) uut (
        .sys_clk(sys_clk), .rst(rst), .trimStartPin(startPin),
        .trimDelaySelect(dlySel), .powerDownInPhase(power_down_in_phase),
        .powerDownQuadrature(power_down_quadrature), .extendedControlMode(extended_control_mode),
        .regReq(regReq), .convData(conv), .laneOut(lanes),
        .outputDataClock(odc), .regRdata(rdata), .trimActiveFlag(flag),
        .outputValid(valid), .powerDownI(pwrI), .powerDownQ(pwrQ),
        .chipPoweredDown(chipDown));
    acs_host_model host (.sys_clk(sys_clk), .regRdata(rdata),
        .regReq(regReq), .trimStartPin(startPin));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [41:0] seen, input logic [41:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic powerUp(input logic d, input logic p);
        rst = 1'b1;
        dlySel = d;
        host.setStart(p);
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        n = 0;
    endtask
    // Counts trim length, then flush length
    task automatic runCal(input int len, input string s);
        n = 0;
        while (!flag) @(negedge sys_clk);
        while (flag) begin
            n++;
            @(negedge sys_clk);
        end
        check(42'(n), 42'(len));
        n = 0;
        while (!valid) begin
            n++;
            @(negedge sys_clk);
        end
        check(42'(n), 42'd60);
        $display("done: %s", s);
    endtask
    task automatic waitFlag();
        while (!flag) begin
            n++;
            @(negedge sys_clk);
        end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        @(negedge sys_clk);
        powerUp(1'b1, 1'b0);
        waitFlag();
        check(42'(n >= 32 && n <= 40), 42'd1);
        powerUp(1'b0, 1'b0);
        waitFlag();
        check(42'(n >= 16 && n <= 24), 42'd1);
        $display("done: power-up delay");
        runCal(6144, "power-up trim");
        powerUp(1'b0, 1'b1);
        repeat (100) @(negedge sys_clk);
        check(42'(flag), 42'd0);
        $display("done: start high at power-up");
        host.acc(1'b0, 4'h4, 16'h0, rv);
        check(42'(rv), 42'h4000);
        host.acc(1'b0, 4'h3, 16'h0, rv);
        check(42'(rv), 42'h0);
        host.acc(1'b1, 4'h4, 16'h5000, rv);
        fork
            host.command();
            runCal(4096, "full trim");
        join
        host.acc(1'b1, 4'h4, 16'h3000, rv);
        fork
            runCal(1124, "suspended trim");
            begin
                repeat (1500) @(negedge sys_clk);
                host.command();
                repeat (200) @(negedge sys_clk);
                {power_down_in_phase, power_down_quadrature} = 2'b11;
                repeat (100) @(negedge sys_clk);
                {power_down_in_phase, power_down_quadrature} = 2'b00;
            end
        join
        dlySel = 1'b1;
        runCal(1024, "delay pin trim");
        check(lanes, conv);
        host.acc(1'b1, 4'hA, 16'h0001, rv);
        repeat (4) @(negedge sys_clk);
        check(42'(pwrI), 42'd0);
        extended_control_mode = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(42'({pwrI, pwrQ}), 42'd2);
        $display("done: power-down control");
        host.acc(1'b1, 4'hA, 16'h0000, rv);
        extended_control_mode = 1'b0;
        host.acc(1'b1, 4'h4, 16'h4080, rv);
        host.acc(1'b0, 4'h5, 16'h0, rv);
        check(42'(rv), 42'h0);
        {power_down_in_phase, power_down_quadrature} = 2'b11;
        repeat (4) @(negedge sys_clk);
        check(42'(chipDown), 42'd1);
        for (int i = 0; i < 185; i++)
            host.acc(1'b1, 4'h5, 16'hA000 + 16'(i), rv);
        host.acc(1'b1, 4'h4, 16'h4000, rv);
        host.acc(1'b1, 4'h4, 16'h4080, rv);
        for (int i = 0; i < 184; i++) begin
            host.acc(1'b0, 4'h5, 16'h0, rv);
            check(42'(rv), i == 0 ? 42'h0 : 42'hA000 + 42'(i - 1));
        end
        host.acc(1'b1, 4'h4, 16'h4000, rv);
        {power_down_in_phase, power_down_quadrature} = 2'b00;
        $display("done: save and restore");
        // Fresh trim after channel power returns, started by register bit
        extended_control_mode = 1'b1;
        host.acc(1'b1, 4'h0, 16'h8000, rv);
        runCal(6144, "register start trim");
        host.acc(1'b1, 4'h0, 16'h0000, rv);
        extended_control_mode = 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
